/* File: design/mac_slice.v */
// Purpose: Multiply-accumulate slice with four element types and AHB regs
// Assumes: Operands and dynamic controls come from logic on SYS_CLK_I
// Notes:   Result output always passes one final flop
// Behaviour
// - Four element types on operands of 9, 18 or 36 bits.
// - Element counts per width fixed; only plain product exists at x36.
// - Input operand registers load in parallel or shift from previous lanes.
// - Dynamic mode lets signedness change every cycle.
// - Dynamic mode lets accumulator add or subtract every cycle.
// - Dynamic mode lets load style switch between parallel and shift.
// - Plain element outputs A times B; all its stages optional.
// - Accumulate element sums products in an output register that is always in use.
// - Accumulator takes an initial value while running.
// - Accumulate element gives a registered overflow flag.
// - Pair element adds or subtracts A1*B1 from A0*B0.
// - Quad element sums two pair results; stages optional.
// - Operand shift chain lets slices be concatenated.
// - Overflow is a one-cycle pulse on unsigned or signed roll-over.
// - Each stage picks tick, enable and reset from four sources.
`timescale 1ns/10ps
`include "mac_slice_regs.vh"

module mac_slice (
	input  wire         SYS_CLK_I,
	input  wire         RST_I,
	input  wire         HSEL_I,
	input  wire [31:0]  HADDR_I,
	input  wire [1:0]   HTRANS_I,
	input  wire         HWRITE_I,
	input  wire [2:0]   HSIZE_I,
	input  wire [31:0]  HWDATA_I,
	input  wire         HREADY_I,
	output reg  [31:0]  HRDATA_O,
	output reg          HREADYOUT_O,
	output reg          HRESP_O,
	input  wire [71:0]  A_I,
	input  wire [71:0]  B_I,
	input  wire [35:0]  SHIFT_IN_A_I,
	input  wire [35:0]  SHIFT_IN_B_I,
	input  wire         SIGNED_I,
	input  wire         SUB_I,
	input  wire         SHIFT_I,
	input  wire         ACC_LOAD_I,
	input  wire [71:0]  ACC_INIT_I,
	input  wire [3:0]   TICK_I,
	input  wire [3:0]   CE_I,
	input  wire [3:0]   SRST_I,
	output wire [35:0]  SHIFT_OUT_A_O,
	output wire [35:0]  SHIFT_OUT_B_O,
	output reg  [143:0] RESULT_O,
	output reg  [1:0]   OVERFLOW_O,
	output reg          IRQ_O
);

// ==========================================================
// Helpers
function [71:0] ext;
	input [143:0] v;
	input [6:0]  n;
	input        s;
	integer      i;
	begin
		for (i = 0; i < 72; i = i + 1) begin
			ext[i] = (i < n) ? v[i] : (s & v[n - 1]);
		end
	end
endfunction

// Stage sources: advance needs the picked tick and the picked enable
function adv_of;
	input [5:0] sel;
	input [3:0] tick;
	input [3:0] ce;
	begin
		adv_of = tick[sel[1:0]] & ce[sel[3:2]];
	end
endfunction

// ==========================================================
// Registers
reg [10:0] ctrl_r;
reg [17:0] sel_r;
reg [1:0]  ovf_st_r;
reg [1:0]  ien_r;
reg        wr_pend_r;
reg [7:0]  wa_r;

wire [1:0] elem = ctrl_r[`CT_ELEM];
wire [1:0] wid = ctrl_r[`CT_WID];
wire       dyn = ctrl_r[`CT_DYN];
wire       cfg_err = (wid == 2'h3) || ((wid == `W36) && (elem != `EL_PLAIN));
wire       is_acc = (elem == `EL_ACC);
wire [1:0] ovf_evt;

function [31:0] rd_mux;
	input [7:0] a;
	begin
		case (a)
			`OFS_CTRL: rd_mux = {21'h0, ctrl_r};
			`OFS_SEL:  rd_mux = {14'h0, sel_r};
			`OFS_STAT: rd_mux = {29'h0, cfg_err, ovf_st_r};
			`OFS_IEN:  rd_mux = {30'h0, ien_r};
			default:   rd_mux = 32'h0;
		endcase
	end
endfunction

wire acc_ph = HSEL_I & HTRANS_I[1] & HREADY_I;
wire do_clr = wr_pend_r && (wa_r == `OFS_ICLR);

always @(posedge SYS_CLK_I or posedge RST_I) begin
	if (RST_I) begin
		ctrl_r <= `CTRL_RST;
		sel_r <= `SEL_RST;
		ien_r <= 2'h0;
		ovf_st_r <= 2'h0;
		wr_pend_r <= 1'b0;
		wa_r <= 8'h00;
		HRDATA_O <= 32'h0;
		HREADYOUT_O <= 1'b1;
		HRESP_O <= 1'b0;
		IRQ_O <= 1'b0;
	end else begin
		// Zero wait states; read data prepared in the address phase
		wr_pend_r <= acc_ph & HWRITE_I;
		wa_r <= HADDR_I[7:0];
		HRDATA_O <= (acc_ph & ~HWRITE_I) ? rd_mux(HADDR_I[7:0]) : 32'h0;
		HREADYOUT_O <= 1'b1;
		HRESP_O <= 1'b0;
		if (wr_pend_r && (wa_r == `OFS_CTRL)) begin
			ctrl_r <= HWDATA_I[10:0];
		end
		if (wr_pend_r && (wa_r == `OFS_SEL)) begin
			sel_r <= HWDATA_I[17:0];
		end
		if (wr_pend_r && (wa_r == `OFS_IEN)) begin
			ien_r <= HWDATA_I[1:0];
		end
		// New overflow beats a simultaneous clear
		ovf_st_r <= (ovf_st_r & ~(do_clr ? HWDATA_I[1:0] : 2'h0)) | ovf_evt;
		IRQ_O <= |(ovf_st_r & ien_r);
	end
end

// ==========================================================
// Stage strobes
wire adv_in = adv_of(sel_r[5:0], TICK_I, CE_I);
wire adv_pp = adv_of(sel_r[11:6], TICK_I, CE_I);
wire adv_out = adv_of(sel_r[17:12], TICK_I, CE_I);
wire clr_in = SRST_I[sel_r[5:4]];
wire clr_pp = SRST_I[sel_r[11:10]];
wire clr_out = SRST_I[sel_r[17:16]];

// ==========================================================
// Input stage with parallel or shift load
wire [218:0] s1_q;
wire [218:0] s1_y;
wire [71:0]  a_q = s1_q[71:0];
wire [71:0]  b_q = s1_q[143:72];
wire         sgn_in = dyn ? SIGNED_I : ctrl_r[`CT_SGN];
wire         sub_in = dyn ? SUB_I : ctrl_r[`CT_SUB];
wire         shf_in = dyn ? SHIFT_I : ctrl_r[`CT_SHIFT];
reg  [71:0]  a_nxt;
reg  [71:0]  b_nxt;

always @* begin
	a_nxt = A_I;
	b_nxt = B_I;
	if (shf_in) begin
		case (wid)
			`W9: begin
				a_nxt = {a_q[62:0], SHIFT_IN_A_I[35:27]};
				b_nxt = {b_q[62:0], SHIFT_IN_B_I[35:27]};
			end
			`W18: begin
				a_nxt = {a_q[53:0], SHIFT_IN_A_I[35:18]};
				b_nxt = {b_q[53:0], SHIFT_IN_B_I[35:18]};
			end
			default: begin
				a_nxt = {a_q[35:0], SHIFT_IN_A_I};
				b_nxt = {b_q[35:0], SHIFT_IN_B_I};
			end
		endcase
	end
end

mac_stage_reg #(.W(219)) u_in (
	.clk_i (SYS_CLK_I),
	.rst_i (RST_I),
	.adv_i (adv_in),
	.clr_i (clr_in),
	.use_i (ctrl_r[`CT_IN_EN]),
	.d_i   ({ACC_LOAD_I, sub_in, sgn_in, ACC_INIT_I, b_nxt, a_nxt}),
	.q_o   (s1_q),
	.y_o   (s1_y)
);

assign SHIFT_OUT_A_O = a_q[71:36];
assign SHIFT_OUT_B_O = b_q[71:36];

// ==========================================================
// Multipliers and pipeline stage
wire [143:0] prod;
wire [218:0] s2_y;

mac_lane_plain_product_element u_plain_product_element (
	.a_i    (s1_y[71:0]),
	.b_i    (s1_y[143:72]),
	.wid_i  (wid),
	.sgn_i  (s1_y[216]),
	.prod_o (prod)
);

mac_stage_reg #(.W(219)) u_pipe (
	.clk_i (SYS_CLK_I),
	.rst_i (RST_I),
	.adv_i (adv_pp),
	.clr_i (clr_pp),
	.use_i (ctrl_r[`CT_PIPE_EN]),
	.d_i   ({s1_y[218:144], prod}),
	.q_o   (),
	.y_o   (s2_y)
);

wire [143:0] p = s2_y[143:0];
wire [71:0]  init = s2_y[215:144];
wire         sgn = s2_y[216];
wire         sub = s2_y[217];
wire         ld = s2_y[218];

// ==========================================================
// Pair, quad and plain results
wire [6:0] pw = (wid == `W9) ? 7'd18 : 7'd36;
reg  [143:0] res;
reg  [71:0]  t0;
reg  [71:0]  t1;
integer      k;

always @* begin
	res = 144'h0;
	t0 = 72'h0;
	t1 = 72'h0;
	case (elem)
		`EL_PLAIN: res = p;
		`EL_PAIR: begin
			for (k = 0; k < 4; k = k + 1) begin
				t0 = ext(p >> (2 * k * pw), pw, sgn);
				t1 = ext(p >> ((2 * k + 1) * pw), pw, sgn);
				t0 = sub ? t0 - t1 : t0 + t1;
				if ((wid == `W9) || (k < 2)) begin
					res = res | ({72'h0, t0 & ((72'h1 << (2 * pw)) - 72'h1)}
						<< (k * 2 * pw));
				end
			end
		end
		`EL_QUAD: begin
			for (k = 0; k < 2; k = k + 1) begin
				t0 = ext(p >> (4 * k * pw), pw, sgn);
				t1 = ext(p >> ((4 * k + 1) * pw), pw, sgn);
				t0 = sub ? t0 - t1 : t0 + t1;
				t1 = ext(p >> ((4 * k + 2) * pw), pw, sgn);
				t1 = sub ? t1 - ext(p >> ((4 * k + 3) * pw), pw, sgn)
					: t1 + ext(p >> ((4 * k + 3) * pw), pw, sgn);
				if ((wid == `W9) || (k == 0)) begin
					res = res | ({72'h0, t0 + t1} << (k * 72));
				end
			end
		end
		default: res = 144'h0;
	endcase
end

// ==========================================================
// Accumulators
wire [7:0]  aw = (wid == `W9) ? `ACC_W9 : `ACC_W18;
wire [71:0] amask = (72'h1 << aw) - 72'h1;
reg  [71:0] acc_nxt [0:1];
reg  [1:0]  ovf_nxt;
reg  [71:0] pe;
reg  [71:0] ao;
reg         sa;
reg         sp;
reg         ss;
integer     j;

always @* begin
	pe = 72'h0;
	ao = 72'h0;
	sa = 1'b0;
	sp = 1'b0;
	ss = 1'b0;
	ovf_nxt = 2'h0;
	for (j = 0; j < 2; j = j + 1) begin
		ao = (j == 0) ? RESULT_O[71:0] : RESULT_O[143:72];
		pe = ext(p >> (j * pw), pw, sgn) & amask;
		acc_nxt[j] = (sub ? ao - pe : ao + pe) & amask;
		sa = |(ao & (72'h1 << (aw - 8'd1)));
		sp = |(pe & (72'h1 << (aw - 8'd1)));
		ss = |(acc_nxt[j] & (72'h1 << (aw - 8'd1)));
		if (sgn) begin
			ovf_nxt[j] = (sub ? (sa != sp) : (sa == sp)) && (ss != sa);
		end else begin
			ovf_nxt[j] = sub ? (acc_nxt[j] > ao) : (acc_nxt[j] < ao);
		end
		if (ld) begin
			acc_nxt[j] = init & amask;
			ovf_nxt[j] = 1'b0;
		end
	end
end

// ==========================================================
// Output register and overflow pulse
assign ovf_evt = OVERFLOW_O;

always @(posedge SYS_CLK_I or posedge RST_I) begin
	if (RST_I) begin
		RESULT_O <= 144'h0;
		OVERFLOW_O <= 2'h0;
	end else begin
		OVERFLOW_O <= 2'h0;
		if (cfg_err) begin
			RESULT_O <= 144'h0;
		end else if (is_acc) begin
			// Accumulator output register is always in use
			if (clr_out) begin
				RESULT_O <= 144'h0;
			end else if (adv_out) begin
				RESULT_O <= {acc_nxt[1], acc_nxt[0]};
				OVERFLOW_O <= ovf_nxt;
			end
		end else if (ctrl_r[`CT_OUT_EN]) begin
			if (clr_out) begin
				RESULT_O <= 144'h0;
			end else if (adv_out) begin
				RESULT_O <= res;
			end
		end else begin
			RESULT_O <= res;
		end
	end
end

endmodule // mac_slice

/* File: design/mac_slice_regs.vh */
// Purpose: Register map, field positions and codes of the MAC slice
// Assumes: 32-bit AHB-Lite register words, byte addresses below
// Notes:   Definitions only
`ifndef MAC_SLICE_REGS_VH
`define MAC_SLICE_REGS_VH

// ==========================================================
// Register offsets
`define OFS_CTRL      8'h00
`define OFS_SEL       8'h04
`define OFS_STAT      8'h08
`define OFS_IEN       8'h0C
`define OFS_ICLR      8'h10

// ==========================================================
// Control word fields
`define CT_ELEM       1:0
`define CT_WID        3:2
`define CT_SGN        4
`define CT_SUB        5
`define CT_DYN        6
`define CT_IN_EN      7
`define CT_PIPE_EN    8
`define CT_OUT_EN     9
`define CT_SHIFT      10
`define CTRL_RST      11'h000
`define SEL_RST       18'h00000

// ==========================================================
// Element and width codes
`define EL_PLAIN      2'h0
`define EL_ACC        2'h1
`define EL_PAIR       2'h2
`define EL_QUAD       2'h3
`define W9            2'h0
`define W18           2'h1
`define W36           2'h2

// ==========================================================
// Accumulator widths per operand width
`define ACC_W9        8'd36
`define ACC_W18       8'd54

`endif

/* File: design/mac_lane_plain_product_element.v */
// Purpose: Lane multipliers of the slice for x9, x18 and x36 operands
// Assumes: Operands packed at the lane width; each lane is extended here
// Notes:   Purely combinational; products packed at twice the lane width
`timescale 1ns/10ps

module mac_lane_plain_product_element (
	input  wire [71:0]  a_i,
	input  wire [71:0]  b_i,
	input  wire [1:0]   wid_i,
	input  wire         sgn_i,
	output reg  [143:0] prod_o
);

// ==========================================================
// Lane extension
function [71:0] ext;
	input [71:0] v;
	input [6:0]  n;
	input        s;
	integer      i;
	begin
		for (i = 0; i < 72; i = i + 1) begin
			ext[i] = (i < n) ? v[i] : (s & v[n - 1]);
		end
	end
endfunction

// ==========================================================
// Products; the low 72 bits of a wide product are exact in two's complement
reg [71:0]  pa;
reg [71:0]  pb;
reg [71:0]  pp;
reg [6:0]   n;
integer     k;
integer     lanes;

always @* begin
	prod_o = 144'h0;
	pa = 72'h0;
	pb = 72'h0;
	pp = 72'h0;
	n = (wid_i == `W9) ? 7'd9 : (wid_i == `W18) ? 7'd18 : 7'd36;
	lanes = (wid_i == `W9) ? 8 : (wid_i == `W18) ? 4 : 1;
	for (k = 0; k < 8; k = k + 1) begin
		if (k < lanes) begin
			pa = ext(a_i >> (k * n), n, sgn_i);
			pb = ext(b_i >> (k * n), n, sgn_i);
			pp = pa * pb;
			prod_o = prod_o | ((pp & ((72'h1 << (2 * n)) - 72'h1))
				<< (k * 2 * n));
		end
	end
end

endmodule // mac_lane_plain_product_element

/* File: design/mac_stage_reg.v */
// Purpose: One optional register stage with selected advance and clear
// Assumes: Advance and clear strobes come from logic on the same clock
// Notes:   Bypassed stage passes d straight through
`timescale 1ns/10ps

module mac_stage_reg #(
	parameter W = 219
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         adv_i,
	input  wire         clr_i,
	input  wire         use_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o,
	output wire [W-1:0] y_o
);

always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		q_o <= {W{1'b0}};
	end else if (clr_i) begin
		q_o <= {W{1'b0}};
	end else if (adv_i) begin
		q_o <= d_i;
	end
end

assign y_o = use_i ? q_o : d_i;

endmodule // mac_stage_reg

/* File: dv/mac_slice_asserts.sv */
// Purpose: Port-level checks of the MAC slice
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound onto every mac_slice instance
`timescale 1ns/10ps
module mac_slice_asserts (
	input wire         SYS_CLK_I,
	input wire         RST_I,
	input wire         HSEL_I,
	input wire [31:0]  HADDR_I,
	input wire [1:0]   HTRANS_I,
	input wire         HWRITE_I,
	input wire         HREADY_I,
	input wire [31:0]  HRDATA_O,
	input wire         HREADYOUT_O,
	input wire         HRESP_O,
	input wire [143:0] RESULT_O,
	input wire [1:0]   OVERFLOW_O,
	input wire         IRQ_O
);
	wire take_rd = HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
	wire take_wr = HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	// ==========================================================
	// Bus
	property p_ready; HREADYOUT_O; endproperty
	a_ready: assert property (p_ready) else $error("slave stalled");
	property p_okay; !HRESP_O; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_rd_idle; !take_rd |=> HRDATA_O == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_rd_unmap;
		take_rd && HADDR_I[7:0] >= 8'h10 |=> HRDATA_O == 32'h0;
	endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
	// ==========================================================
	// Overflow and interrupt
	// An overflow only comes with a newly captured sum
	property p_ovf0;
		OVERFLOW_O[0] |-> RESULT_O[71:0] != $past(RESULT_O[71:0]);
	endproperty
	a_ovf0: assert property (p_ovf0) else $error("overflow 0 early");
	property p_ovf1;
		OVERFLOW_O[1] |-> RESULT_O[143:72] != $past(RESULT_O[143:72]);
	endproperty
	a_ovf1: assert property (p_ovf1) else $error("overflow 1 early");
	property p_irq_rise;
		$rose(IRQ_O) |-> $past(OVERFLOW_O, 2) != 2'h0 || $past(take_wr, 3);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq no cause");
	property p_irq_fall; $fell(IRQ_O) |-> $past(take_wr, 3); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule // mac_slice_asserts

bind mac_slice mac_slice_asserts u_chk (.SYS_CLK_I(SYS_CLK_I),
	.RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
	.HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.RESULT_O(RESULT_O), .OVERFLOW_O(OVERFLOW_O), .IRQ_O(IRQ_O));

/* File: dv/fabric_model.sv */
// Purpose: Fabric side supplying operands and per-cycle controls
// Assumes: op is called just after a rising edge
// Notes:   Lanes are packed at the lane width; the slice extends each lane
`timescale 1ns/10ps
module fabric_model (
	output reg  [71:0] a_o,
	output reg  [71:0] b_o,
	output reg         sgn_o,
	output reg         sub_o,
	output reg         ld_o,
	output reg         shf_o,
	output reg  [71:0] init_o
);
	initial begin
		{a_o, b_o, sgn_o, sub_o, ld_o, shf_o, init_o} = 220'h0;
	end
	// One signedness and one width for all lanes of a call
	task op(input [71:0] a, b, input ld, sub, sgn, input [71:0] i);
		{a_o, b_o, ld_o, sub_o, sgn_o, init_o} <= {a, b, ld, sub, sgn, i};
	endtask
	// Per-cycle choice of parallel or shift load
	task load_style(input s);
		shf_o <= s;
	endtask
endmodule // fabric_model

/* File: dv/mac_slice_test.sv */
// Purpose: Self-checking bench of the MAC slice
// Assumes: Strobes held active except in the output stage checks; chain outputs fed back to chain inputs
// Notes:   Random operands from a fixed seed plus corner cases
`timescale 1ns/10ps
`include "mac_slice_regs.vh"
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module mac_slice_test;
	logic         clk, rst, hsel, hwrite;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic [31:0]  haddr, hwdata, rd;
	logic [71:0]  x, y, rx, ry;
	logic [3:0]   tk, ce, sr;
	logic [143:0] ev;
	wire  [35:0]  soa, sob;
	wire  [31:0]  hrdata;
	wire          hready, irq, fsg, fsu, fld, fsh;
	wire  [143:0] res;
	wire  [1:0]   ovf;
	wire  [71:0]  fa, fb, fi;
	int           errors = 0;
	int           checks = 0;
	int           m, k, s;
	logic [10:0]  cf [4] = '{11'h000, 11'h014, 11'h180, 11'h008};
	int           wv [4] = '{9, 18, 9, 36};
	int           lt [4] = '{1, 1, 3, 1};

	fabric_model u_fab (.a_o(fa), .b_o(fb), .sgn_o(fsg), .sub_o(fsu),
		.ld_o(fld), .shf_o(fsh), .init_o(fi));
	mac_slice u_dut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
		.A_I(fa), .B_I(fb), .SHIFT_IN_A_I(soa), .SHIFT_IN_B_I(sob),
		.SIGNED_I(fsg), .SUB_I(fsu), .SHIFT_I(fsh), .ACC_LOAD_I(fld),
		.ACC_INIT_I(fi), .TICK_I(tk), .CE_I(ce), .SRST_I(sr),
		.SHIFT_OUT_A_O(soa), .SHIFT_OUT_B_O(sob), .RESULT_O(res),
		.OVERFLOW_O(ovf), .IRQ_O(irq));

	// ==========================================================
	// Expectations
	// Lane product, extended by hand so truncation matches the slot
	function automatic logic [143:0] lp(input logic [71:0] a, b,
		input int w, n, input logic sg);
		logic [145:0] p, q;
		p = (a >> (w * n)) & ((146'h1 << w) - 1);
		q = (b >> (w * n)) & ((146'h1 << w) - 1);
		if (sg && p[w-1])
			p = p - (146'h1 << w);
		if (sg && q[w-1])
			q = q - (146'h1 << w);
		lp = 144'(p * q) & ((144'h1 << (2 * w)) - 1);
	endfunction
	function automatic logic [143:0] sl(input logic [143:0] r, input int w,
		input int n);
		sl = (r >> (w * n)) & ((144'h1 << w) - 1);
	endfunction

	// ==========================================================
	// Bus master
	task test_done;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task hwait;
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1) begin
			@(negedge clk);
			r = hready;
			rd = hrdata;
			tick(1);
			n++;
			if (n > 16) begin
				errors++;
				test_done;
			end
		end
	endtask
	task ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ad};
		hwrite <= w;
		hwait;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hwait;
	endtask
	task rchk(input logic [7:0] ad, input logic [31:0] e);
		ahb(1'b0, ad, 32'h0);
		`CHK("register", e, rd)
	endtask
	// Interrupt follows a register write one edge after it lands
	task wirq(input logic [7:0] ad, input logic [31:0] d, input logic e);
		ahb(1'b1, ad, d);
		tick(1);
		`CHK("irq", e, irq)
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst, hsel, hwrite, htrans, hsize} = {1'b1, 7'h02};
		{tk, ce, sr} = 12'hFF0;
		{haddr, hwdata} = 64'h0;
		s = $urandom(32'h7E76BBB5);
		tick(12);
		rst <= 1'b0;
		for (m = 0; m < 24; m += 4)
			rchk(8'(m), 32'h0);
		ahb(1'b1, `OFS_SEL, 32'hFFFFFFFF);
		rchk(`OFS_SEL, 32'h3FFFF);
		ahb(1'b1, 8'h20, 32'h1);
		rchk(8'h20, 32'h0);
		for (m = 0; m < 4; m++) begin
			ahb(1'b1, `OFS_CTRL, {21'h0, cf[m]});
			repeat (3) begin
				x = 72'({$urandom, $urandom, $urandom});
				y = 72'({$urandom, $urandom, $urandom});
				u_fab.op(x, y, 1'b0, 1'b0, cf[m][4], 72'h0);
				tick(lt[m]);
				for (k = 0; k < (wv[m] == 36 ? 1 : 72 / wv[m]); k++) begin
					ev = lp(x, y, wv[m], k, cf[m][4]);
					`CHK("plain", ev, sl(res, 2 * wv[m], k))
				end
			end
		end
		ahb(1'b1, `OFS_CTRL, 32'h22);
		u_fab.op(x, y, 1'b0, 1'b0, 1'b0, 72'h0);
		tick(1);
		for (k = 0; k < 4; k++) begin
			ev = lp(x, y, 9, 2 * k, 0) - lp(x, y, 9, 2 * k + 1, 0);
			`CHK("pair", ev & 144'hFFFFFFFFF, sl(res, 36, k))
		end
		ahb(1'b1, `OFS_CTRL, 32'h07);
		tick(1);
		ev = lp(x, y, 18, 0, 0) + lp(x, y, 18, 1, 0);
		ev = (ev + lp(x, y, 18, 2, 0) + lp(x, y, 18, 3, 0));
		`CHK("quad", ev & 144'hFFFFFFFFFFFFFFFFFF, sl(res, 72, 0))
		// Accumulator: load near the top, then roll over once
		ahb(1'b1, `OFS_IEN, 32'h1);
		ahb(1'b1, `OFS_CTRL, 32'h01);
		u_fab.op(72'h0, 72'h0, 1'b1, 1'b0, 1'b0, {2{36'hFFFFFFF00}});
		tick(1);
		u_fab.op(72'h1FF, 72'h1FF, 1'b0, 1'b0, 1'b0, 72'h0);
		`CHK("init", 72'hFFFFFFF00, res[71:0])
		tick(1);
		u_fab.op(72'h0, 72'h0, 1'b0, 1'b0, 1'b0, 72'h0);
		`CHK("sum", 72'h3FB01, res[71:0])
		`CHK("ovf", 2'h1, ovf)
		tick(1);
		`CHK("pulse", 2'h0, ovf)
		tick(1);
		`CHK("irq", 1'b1, irq)
		rchk(`OFS_STAT, 32'h1);
		wirq(`OFS_IEN, 32'h0, 1'b0);
		wirq(`OFS_IEN, 32'h1, 1'b1);
		wirq(`OFS_ICLR, 32'h1, 1'b0);
		// Dynamic mode: subtract to a borrow, then a signed product
		ahb(1'b1, `OFS_CTRL, 32'h41);
		u_fab.op(72'h0, 72'h0, 1'b1, 1'b0, 1'b0, {2{36'h10}});
		tick(1);
		u_fab.op(72'h3, 72'h3, 1'b0, 1'b1, 1'b0, 72'h0);
		tick(1);
		`CHK("sub", 72'h7, res[71:0])
		tick(1);
		u_fab.op(72'h1FF, 72'h1, 1'b0, 1'b0, 1'b1, 72'h0);
		`CHK("borrow", 72'hFFFFFFFFE, res[71:0])
		`CHK("borrow ovf", 2'h1, ovf)
		tick(1);
		u_fab.op(72'h0, 72'h0, 1'b1, 1'b0, 1'b1, {2{36'h7FFFFFFF0}});
		`CHK("signed", 72'hFFFFFFFFD, res[71:0])
		`CHK("signed ovf", 2'h0, ovf)
		tick(1);
		// Two positive values give a negative sum in both accumulators
		u_fab.op(72'h1FEFF, 72'h1FEFF, 1'b0, 1'b0, 1'b1, 72'h0);
		tick(1);
		u_fab.op(72'h0, 72'h0, 1'b0, 1'b0, 1'b0, 72'h0);
		`CHK("signed roll", {2{72'h80000FDF1}}, res)
		`CHK("both ovf", 2'h3, ovf)
		tick(2);
		wirq(`OFS_ICLR, 32'h3, 1'b0);
		// Shift load with the chain fed back: lanes rotate by one slot
		ahb(1'b1, `OFS_CTRL, 32'hC0);
		u_fab.op(x, y, 1'b0, 1'b0, 1'b0, 72'h0);
		rx = {x[62:0], x[71:63]};
		ry = {y[62:0], y[71:63]};
		tick(1);
		u_fab.load_style(1'b1);
		`CHK("chain a", x[71:36], soa)
		tick(1);
		u_fab.load_style(1'b0);
		`CHK("chain b", ry[71:36], sob)
		for (k = 0; k < 8; k++)
			`CHK("direct", lp(x, y, 9, k, 0), sl(res, 18, k))
		tick(1);
		for (k = 0; k < 8; k++)
			`CHK("shifted", lp(rx, ry, 9, k, 0), sl(res, 18, k))
		// Output stage strobes, all picked through source index 3
		ahb(1'b1, `OFS_CTRL, 32'h200);
		u_fab.op(x, y, 1'b0, 1'b0, 1'b0, 72'h0);
		tick(1);
		u_fab.op(72'h0, 72'h0, 1'b0, 1'b0, 1'b0, 72'h0);
		tk <= 4'h7;
		tick(1);
		`CHK("tick hold", lp(x, y, 9, 0, 0), sl(res, 18, 0))
		{tk, ce} <= 8'hF7;
		tick(1);
		`CHK("enable hold", lp(x, y, 9, 0, 0), sl(res, 18, 0))
		{ce, sr} <= 8'hF8;
		tick(1);
		sr <= 4'h0;
		`CHK("stage clear", 144'h0, res)
		// Accumulate at x36 has no element: result held at zero
		ahb(1'b1, `OFS_CTRL, 32'h09);
		u_fab.op(x, y, 1'b0, 1'b0, 1'b0, 72'h0);
		tick(2);
		`CHK("cfg result", 144'h0, res)
		rchk(`OFS_STAT, 32'h4);
		test_done;
	end
endmodule // mac_slice_test
